// ==== verilog/pabo_map.vh ====
`ifndef PABO_MAP_VH
`define PABO_MAP_VH
// Second-port pin positions.
`define PABO_SCK_BIT      3'd7
`define PABO_MISO_BIT     3'd6
`define PABO_MOSI_BIT     3'd5
`define PABO_SS_BIT       3'd4
`define PABO_TIMER0_COMPARE_A_OUT_BIT     3'd3
`define PABO_CMP_NEG_BIT  3'd3
`define PABO_CMP_POS_BIT  3'd2
`define PABO_IRQ2_BIT     3'd2
`define PABO_DIVIDED_CLOCK_OUT_BIT     3'd1
`define PABO_T1_BIT       3'd1
// Pull-up enabled by ordinary port bits when {dir,out,pud} equals this code.
`define PABO_PULLUP_CODE  3'b010
// Output reset values.
`define PABO_RST_BYTE     8'h00
`define PABO_RST_BIT      1'b0
`endif

// ==== verilog/pabo_pin_mux.v ====
`timescale 1ns/100ps
`include "pabo_map.vh"
// One pin: override signals resolved into pull-up, driver, value, input enable.
module pabo_pin_mux (
  // Port register bits
  input  wire port_dir_bit_i,
  input  wire port_out_bit_i,
  input  wire global_pullup_disable_i,
  input  wire sleep_i,
  // Overrides
  input  wire pullup_override_en_i,
  input  wire pullup_override_val_i,
  input  wire direction_override_en_i,
  input  wire direction_override_val_i,
  input  wire value_override_en_i,
  input  wire value_override_val_i,
  input  wire input_en_override_en_i,
  input  wire input_en_override_val_i,
  // Resolved pin controls
  output wire pullup_en_o,
  output wire drive_en_o,
  output wire drive_val_o,
  output wire input_en_o
);
  assign pullup_en_o = pullup_override_en_i ? pullup_override_val_i :
         ({port_dir_bit_i, port_out_bit_i, global_pullup_disable_i} == `PABO_PULLUP_CODE);
  assign drive_en_o  = direction_override_en_i ? direction_override_val_i : port_dir_bit_i;
  assign drive_val_o = value_override_en_i ? value_override_val_i : port_out_bit_i;
  assign input_en_o  = input_en_override_en_i ? input_en_override_val_i : ~sleep_i;
endmodule // pabo_pin_mux

// ==== verilog/pabo_byte_reg.v ====
`timescale 1ns/100ps
`include "pabo_map.vh"
// Eight-bit output register with synchronous reset.
module pabo_byte_reg (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // Data
  input  wire [7:0] d_i,
  output reg  [7:0] q_o
);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      q_o <= `PABO_RST_BYTE;
    end else begin
      q_o <= d_i;
    end
  end
endmodule // pabo_byte_reg

// ==== verilog/pabo_top.v ====
`timescale 1ns/100ps
`include "pabo_map.vh"
module pabo_top (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // Global controls
  input  wire       global_pullup_disable_i,
  input  wire       sleep_i,
  input  wire       clock_out_fuse_i,
  input  wire       divided_clock_i,
  // Analog port register bits and controls
  input  wire [7:0] pa_dir_i,
  input  wire [7:0] pa_out_i,
  input  wire [7:0] pa_pin_i,
  input  wire [7:0] pin_change_mask_lo_i,
  input  wire       pin_change_group0_en_i,
  input  wire [7:0] analog_input_digital_disable_i,
  // Second port register bits and controls
  input  wire [7:0] pb_dir_i,
  input  wire [7:0] pb_out_i,
  input  wire [7:0] pb_pin_i,
  input  wire [7:0] pin_change_mask_hi_i,
  input  wire       pin_change_group1_en_i,
  input  wire       ext_irq_2_en_i,
  // SPI
  input  wire       spi_en_i,
  input  wire       spi_master_i,
  input  wire       spi_sck_out_i,
  input  wire       spi_slave_out_i,
  input  wire       spi_master_out_i,
  // Timer 0 compare
  input  wire       timer0_compare_a_en_i,
  input  wire       timer0_compare_a_out_i,
  input  wire       timer0_compare_b_en_i,
  input  wire       timer0_compare_b_out_i,
  // Analog port resolved pin controls
  output wire [7:0] pa_pullup_en_o,
  output wire [7:0] pa_drive_en_o,
  output wire [7:0] pa_drive_val_o,
  output wire [7:0] pa_input_en_o,
  // Second port resolved pin controls
  output reg  [7:0] pb_pullup_en_o,
  output reg  [7:0] pb_drive_en_o,
  output reg  [7:0] pb_drive_val_o,
  output reg  [7:0] pb_input_en_o,
  // Digital inputs to peripherals
  output reg  [15:0] pin_change_src_o,
  output reg         spi_sck_in_o,
  output reg         spi_master_in_o,
  output reg         spi_slave_in_o,
  output reg         spi_slave_select_o,
  output reg         ext_irq_2_o,
  output reg         timer1_count_in_o,
  output wire        comparator_neg_in_o,
  output wire        comparator_pos_in_o
);
  wire       spi_slave_mode  = spi_en_i & ~spi_master_i;
  wire       spi_master_mode = spi_en_i & spi_master_i;

  wire [7:0] nxt_pa_pullup;
  wire [7:0] nxt_pa_drive_en;
  wire [7:0] nxt_pa_drive_val;
  wire [7:0] nxt_pa_input_en;
  wire [7:0] nxt_pb_pullup;
  wire [7:0] nxt_pb_drive_en;
  wire [7:0] nxt_pb_drive_val;
  wire [7:0] nxt_pb_input_en;

  reg  [7:0] pb_pullup_override_en;
  reg  [7:0] pb_pullup_override_val;
  reg  [7:0] pb_direction_override_en;
  reg  [7:0] pb_direction_override_val;
  reg  [7:0] pb_value_override_en;
  reg  [7:0] pb_value_override_val;
  reg  [7:0] pb_input_en_override_en;
  wire [7:0] pa_input_en_override_en;
  wire [7:0] pa_input_en_override_val;

  assign pa_input_en_override_en = (pin_change_mask_lo_i & {8{pin_change_group0_en_i}})
                  | analog_input_digital_disable_i;
  assign pa_input_en_override_val = pin_change_mask_lo_i & {8{pin_change_group0_en_i}};

  always @* begin
    pb_pullup_override_en  = 8'h00;
    pb_pullup_override_val  = 8'h00;
    pb_direction_override_en  = 8'h00;
    pb_direction_override_val  = 8'h00;
    pb_value_override_en  = 8'h00;
    pb_value_override_val  = 8'h00;
    pb_input_en_override_en = pin_change_mask_hi_i & {8{pin_change_group1_en_i}};
    if (spi_slave_mode) begin
      pb_direction_override_en[`PABO_SCK_BIT]  = 1'b1;
      pb_direction_override_en[`PABO_MOSI_BIT] = 1'b1;
      pb_direction_override_en[`PABO_SS_BIT]   = 1'b1;
      pb_pullup_override_en[`PABO_SCK_BIT]  = 1'b1;
      pb_pullup_override_en[`PABO_MOSI_BIT] = 1'b1;
      pb_pullup_override_en[`PABO_SS_BIT]   = 1'b1;
      pb_pullup_override_val[`PABO_SCK_BIT]  = pb_out_i[`PABO_SCK_BIT] & ~global_pullup_disable_i;
      pb_pullup_override_val[`PABO_MOSI_BIT] = pb_out_i[`PABO_MOSI_BIT] & ~global_pullup_disable_i;
      pb_pullup_override_val[`PABO_SS_BIT]   = pb_out_i[`PABO_SS_BIT] & ~global_pullup_disable_i;
      // Slave drives its data-out pin when software opens the driver.
      pb_value_override_en[`PABO_MISO_BIT] = 1'b1;
      pb_value_override_val[`PABO_MISO_BIT] = spi_slave_out_i;
    end
    if (spi_master_mode) begin
      pb_direction_override_en[`PABO_MISO_BIT] = 1'b1;
      pb_pullup_override_en[`PABO_MISO_BIT] = 1'b1;
      pb_pullup_override_val[`PABO_MISO_BIT] = pb_out_i[`PABO_MISO_BIT] & ~global_pullup_disable_i;
      pb_value_override_en[`PABO_SCK_BIT]  = 1'b1;
      pb_value_override_val[`PABO_SCK_BIT]  = spi_sck_out_i;
      pb_value_override_en[`PABO_MOSI_BIT] = 1'b1;
      pb_value_override_val[`PABO_MOSI_BIT] = spi_master_out_i;
    end
    if (timer0_compare_b_en_i) begin
      pb_value_override_en[`PABO_SS_BIT] = 1'b1;
      pb_value_override_val[`PABO_SS_BIT] = timer0_compare_b_out_i;
    end
    if (timer0_compare_a_en_i) begin
      pb_value_override_en[`PABO_TIMER0_COMPARE_A_OUT_BIT] = 1'b1;
      pb_value_override_val[`PABO_TIMER0_COMPARE_A_OUT_BIT] = timer0_compare_a_out_i;
    end
    if (clock_out_fuse_i) begin
      pb_direction_override_en[`PABO_DIVIDED_CLOCK_OUT_BIT] = 1'b1;
      pb_direction_override_val[`PABO_DIVIDED_CLOCK_OUT_BIT] = 1'b1;
      pb_value_override_en[`PABO_DIVIDED_CLOCK_OUT_BIT] = 1'b1;
      pb_value_override_val[`PABO_DIVIDED_CLOCK_OUT_BIT] = divided_clock_i;
    end
    // Interrupt 2 keeps the input alive.
    if (ext_irq_2_en_i) begin
      pb_input_en_override_en[`PABO_IRQ2_BIT] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      pabo_pin_mux u_pa (
        .port_dir_bit_i          (pa_dir_i[g]),
        .port_out_bit_i          (pa_out_i[g]),
        .global_pullup_disable_i (global_pullup_disable_i),
        .sleep_i                 (sleep_i),
        .pullup_override_en_i    (1'b0),
        .pullup_override_val_i   (1'b0),
        .direction_override_en_i (1'b0),
        .direction_override_val_i(1'b0),
        .value_override_en_i     (1'b0),
        .value_override_val_i    (1'b0),
        .input_en_override_en_i  (pa_input_en_override_en[g]),
        .input_en_override_val_i (pa_input_en_override_val[g]),
        .pullup_en_o             (nxt_pa_pullup[g]),
        .drive_en_o              (nxt_pa_drive_en[g]),
        .drive_val_o             (nxt_pa_drive_val[g]),
        .input_en_o              (nxt_pa_input_en[g])
      );
      pabo_pin_mux u_pb (
        .port_dir_bit_i          (pb_dir_i[g]),
        .port_out_bit_i          (pb_out_i[g]),
        .global_pullup_disable_i (global_pullup_disable_i),
        .sleep_i                 (sleep_i),
        .pullup_override_en_i    (pb_pullup_override_en[g]),
        .pullup_override_val_i   (pb_pullup_override_val[g]),
        .direction_override_en_i (pb_direction_override_en[g]),
        .direction_override_val_i(pb_direction_override_val[g]),
        .value_override_en_i     (pb_value_override_en[g]),
        .value_override_val_i    (pb_value_override_val[g]),
        .input_en_override_en_i  (pb_input_en_override_en[g]),
        .input_en_override_val_i (1'b1),
        .pullup_en_o             (nxt_pb_pullup[g]),
        .drive_en_o              (nxt_pb_drive_en[g]),
        .drive_val_o             (nxt_pb_drive_val[g]),
        .input_en_o              (nxt_pb_input_en[g])
      );
    end
  endgenerate

  // Analog port pin controls are plain reset registers.
  pabo_byte_reg u_pa_pullup_reg (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (nxt_pa_pullup),
    .q_o        (pa_pullup_en_o)
  );
  pabo_byte_reg u_pa_drive_en_reg (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (nxt_pa_drive_en),
    .q_o        (pa_drive_en_o)
  );
  pabo_byte_reg u_pa_drive_val_reg (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (nxt_pa_drive_val),
    .q_o        (pa_drive_val_o)
  );
  pabo_byte_reg u_pa_input_en_reg (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (nxt_pa_input_en),
    .q_o        (pa_input_en_o)
  );

  // Registered pin controls; the second-port driver bytes, clock-out pin included, are an exception, see below.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pb_pullup_en_o     <= `PABO_RST_BYTE;
      pb_input_en_o      <= `PABO_RST_BYTE;
      pin_change_src_o   <= 16'h0000;
      spi_sck_in_o       <= `PABO_RST_BIT;
      spi_master_in_o    <= `PABO_RST_BIT;
      spi_slave_in_o     <= `PABO_RST_BIT;
      spi_slave_select_o <= `PABO_RST_BIT;
      ext_irq_2_o        <= `PABO_RST_BIT;
      timer1_count_in_o  <= `PABO_RST_BIT;
    end else begin
      pb_pullup_en_o     <= nxt_pb_pullup;
      pb_input_en_o      <= nxt_pb_input_en;
      pin_change_src_o[7:0]  <= pa_pin_i & nxt_pa_input_en;
      pin_change_src_o[15:8] <= pb_pin_i & nxt_pb_input_en;
      spi_sck_in_o       <= pb_pin_i[`PABO_SCK_BIT];
      spi_master_in_o    <= pb_pin_i[`PABO_MISO_BIT];
      spi_slave_in_o     <= pb_pin_i[`PABO_MOSI_BIT];
      spi_slave_select_o <= spi_slave_mode & ~pb_pin_i[`PABO_SS_BIT];
      ext_irq_2_o        <= pb_pin_i[`PABO_IRQ2_BIT];
      timer1_count_in_o  <= pb_pin_i[`PABO_T1_BIT];
    end
  end

  // clock out during reset.
  // The driver register ignores reset, since the fused clock must keep running.
  always @(posedge core_clk_i) begin
    pb_drive_en_o  <= nxt_pb_drive_en;
    pb_drive_val_o <= nxt_pb_drive_val;
  end

  // comparator direct wiring.
  // The comparator pins bypass registers because they are analog taps.
  assign comparator_neg_in_o = pb_pin_i[`PABO_CMP_NEG_BIT];
  assign comparator_pos_in_o = pb_pin_i[`PABO_CMP_POS_BIT];
endmodule // pabo_top

// ==== testbench/pabo_top_properties.sv ====
`timescale 1ns/100ps
module pabo_top_properties (
  // Clock, reset and controls
  input wire       core_clk_i,
  input wire       rst_i,
  input wire       global_pullup_disable_i,
  input wire       sleep_i,
  input wire       clock_out_fuse_i,
  input wire       divided_clock_i,
  input wire [7:0] pa_dir_i,
  input wire [7:0] pa_out_i,
  input wire [7:0] pin_change_mask_lo_i,
  input wire       pin_change_group0_en_i,
  input wire [7:0] analog_input_digital_disable_i,
  input wire [7:0] pb_out_i,
  input wire [7:0] pb_pin_i,
  input wire       spi_en_i,
  input wire       spi_master_i,
  // Watched outputs
  input wire [7:0] pa_pullup_en_o,
  input wire [7:0] pa_input_en_o,
  input wire [7:0] pb_pullup_en_o,
  input wire [7:0] pb_drive_en_o,
  input wire [7:0] pb_drive_val_o,
  input wire       spi_slave_select_o,
  input wire       comparator_neg_in_o,
  input wire       comparator_pos_in_o
);
  wire       slv = spi_en_i & ~spi_master_i;
  wire [7:0] ov  = pin_change_mask_lo_i & {8{pin_change_group0_en_i}};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  pa_pullup_a: assert property (!$past(rst_i) |-> pa_pullup_en_o ==
    $past(~pa_dir_i & pa_out_i & {8{~global_pullup_disable_i}})) else $error("pa pullup");
  pa_input_a: assert property (!$past(rst_i) |-> pa_input_en_o == $past(ov |
    (~(ov | analog_input_digital_disable_i) & {8{~sleep_i}}))) else $error("pa input");
  spi_slave_a: assert property (!$past(rst_i) && $past(slv) |->
    pb_drive_en_o[7] == 1'b0 && pb_drive_en_o[5:4] == 2'b00) else $error("slave dir");
  spi_master_a: assert property (!$past(rst_i) && $past(spi_en_i & spi_master_i) |->
    pb_drive_en_o[6] == 1'b0) else $error("master dir");
  forced_pullup_a: assert property (!$past(rst_i) && $past(slv) |->
    pb_pullup_en_o[7] == $past(pb_out_i[7] & ~global_pullup_disable_i)) else $error("pullup");
  clock_out_a: assert property (disable iff (1'b0) $past(clock_out_fuse_i) |->
    pb_drive_en_o[1] && pb_drive_val_o[1] == $past(divided_clock_i)) else $error("clkout");
  comparator_a: assert property (comparator_neg_in_o == pb_pin_i[3] &&
    comparator_pos_in_o == pb_pin_i[2]) else $error("comparator");
  slave_select_a: assert property (!$past(rst_i) |-> spi_slave_select_o ==
    $past(slv & ~pb_pin_i[4])) else $error("select");
endmodule // pabo_top_properties
bind pabo_top pabo_top_properties pabo_top_properties_inst (.*);

// ==== testbench/pabo_pad_model.sv ====
`timescale 1ns/100ps
module pabo_pad_model (
  // Clock
  input wire        core_clk_i,
  // Pin controls and outside driver
  input wire [7:0]  pullup_en_i,
  input wire [7:0]  drive_en_i,
  input wire [7:0]  drive_val_i,
  input wire [7:0]  ext_en_i,
  input wire [7:0]  ext_val_i,
  // Pad level
  output wire [7:0] pad_o
);
  // Floating pads toggle so a stale level is never mistaken for a real one.
  reg [7:0] float_ff = 8'h00;
  always @(posedge core_clk_i) begin
    float_ff <= ~float_ff;
  end
  assign pad_o = (drive_en_i & drive_val_i) | (~drive_en_i & ext_en_i & ext_val_i)
    | (~drive_en_i & ~ext_en_i & (pullup_en_i | float_ff));
endmodule // pabo_pad_model

// ==== testbench/pabo_top_test.sv ====
`timescale 1ns/100ps
module pabo_top_test;
  logic core_clk_i = 0, rst_i = 1, global_pullup_disable_i = 0, sleep_i = 0;
  logic clock_out_fuse_i = 0, divided_clock_i = 0, pin_change_group0_en_i = 0;
  logic pin_change_group1_en_i = 0, ext_irq_2_en_i = 0, spi_en_i = 0, spi_master_i = 0;
  logic spi_sck_out_i = 0, spi_slave_out_i = 0, spi_master_out_i = 0;
  logic timer0_compare_a_en_i = 0, timer0_compare_a_out_i = 0;
  logic timer0_compare_b_en_i = 0, timer0_compare_b_out_i = 0;
  logic [7:0] pa_dir_i = 0, pa_out_i = 0, pin_change_mask_lo_i = 0, pb_dir_i = 0;
  logic [7:0] analog_input_digital_disable_i = 0, pb_out_i = 0, pin_change_mask_hi_i = 0;
  logic [7:0] pa_ext_en = 0, pa_ext_val = 0, pb_ext_en = 0, pb_ext_val = 0;
  wire [7:0] pa_pin_i, pb_pin_i, pa_pullup_en_o, pa_drive_en_o, pa_drive_val_o;
  wire [7:0] pa_input_en_o, pb_pullup_en_o, pb_drive_en_o, pb_drive_val_o, pb_input_en_o;
  wire [15:0] pin_change_src_o;
  wire spi_sck_in_o, spi_master_in_o, spi_slave_in_o, spi_slave_select_o;
  wire ext_irq_2_o, timer1_count_in_o, comparator_neg_in_o, comparator_pos_in_o;
  logic [7:0] de [3] = '{8'hff, 8'h4f, 8'hbf};
  logic [7:0] pu [3] = '{8'h00, 8'hb0, 8'h40};
  logic [7:0] dv [3] = '{8'hf0, 8'hb0, 8'h50};
  int n_mismatch = 0, check_count = 0, cyc = 0;
  pabo_top pabo_top_inst (.*);
  pabo_pad_model pabo_pad_model_inst (.core_clk_i(core_clk_i), .pullup_en_i(pa_pullup_en_o),
    .drive_en_i(pa_drive_en_o), .drive_val_i(pa_drive_val_o), .ext_en_i(pa_ext_en),
    .ext_val_i(pa_ext_val), .pad_o(pa_pin_i));
  pabo_pad_model pabo_pad_model_inst2 (.core_clk_i(core_clk_i), .pullup_en_i(pb_pullup_en_o),
    .drive_en_i(pb_drive_en_o), .drive_val_i(pb_drive_val_o), .ext_en_i(pb_ext_en),
    .ext_val_i(pb_ext_val), .pad_o(pb_pin_i));
  always #4 core_clk_i = ~core_clk_i;
  // The whole run needs well under a hundred cycles.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task step(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    step(5);
    rst_i = 0;
    pa_dir_i = 8'h0f; pa_out_i = 8'h35; pin_change_mask_lo_i = 8'ha5;
    pin_change_group0_en_i = 1; analog_input_digital_disable_i = 8'h18;
    pa_ext_en = 8'hf0; pa_ext_val = 8'hc0;
    for (int i = 0; i < 2; i++) begin
      sleep_i = i[0]; global_pullup_disable_i = i[0]; step(3);
      chk(pa_drive_en_o, 8'h0f);
      chk(pa_drive_val_o, 8'h35);
      chk(pa_pullup_en_o, i ? 8'h00 : 8'h30);
      chk(pa_input_en_o, i ? 8'ha5 : 8'he7);
      chk(pin_change_src_o[7:0], 8'hc5 & (i ? 8'ha5 : 8'he7));
    end
    $display("analog port test done");
    sleep_i = 0; global_pullup_disable_i = 0; pb_dir_i = 8'hff; pb_out_i = 8'hf0;
    pb_ext_en = 8'h10;
    for (int i = 0; i < 3; i++) begin
      spi_en_i = (i != 0); spi_master_i = (i == 2); step(3);
      chk(pb_drive_en_o, de[i]);
      chk(pb_pullup_en_o, pu[i]);
      chk(pb_drive_val_o, dv[i]);
      chk(spi_slave_select_o, i == 1);
    end
    $display("spi test done");
    spi_en_i = 0; pb_ext_en = 8'h00; pb_dir_i = 8'h18; pb_out_i = 8'h10;
    timer0_compare_a_en_i = 1; timer0_compare_b_en_i = 1;
    for (int i = 0; i < 2; i++) begin
      timer0_compare_a_out_i = ~i[0]; timer0_compare_b_out_i = i[0]; step(2);
      chk(pb_drive_en_o[4:3], 2'b11);
      chk(pb_drive_val_o[4:3], i ? 2'b10 : 2'b01);
    end
    pb_dir_i = 8'h00; step(2);
    chk(pb_drive_en_o[4:3], 2'b00);
    $display("compare test done");
    timer0_compare_a_en_i = 0; timer0_compare_b_en_i = 0; pb_ext_en = 8'hff;
    pin_change_mask_hi_i = 8'hff; pin_change_group1_en_i = 1;
    for (int i = 0; i < 2; i++) begin
      pb_ext_val = i ? 8'ha5 : 8'h5a; sleep_i = i[0]; step(3);
      chk(pin_change_src_o[15:8], pb_ext_val);
      chk({comparator_neg_in_o, comparator_pos_in_o}, pb_ext_val[3:2]);
      chk({ext_irq_2_o, timer1_count_in_o}, pb_ext_val[2:1]);
      chk({spi_sck_in_o, spi_master_in_o, spi_slave_in_o}, pb_ext_val[7:5]);
    end
    pin_change_mask_hi_i = 8'h00; ext_irq_2_en_i = 1; step(3);
    chk(pb_input_en_o, 8'h04);
    chk(pin_change_src_o[15:8], pb_ext_val & 8'h04);
    ext_irq_2_en_i = 0;
    $display("input routing test done");
    sleep_i = 0; clock_out_fuse_i = 1;
    for (int i = 0; i < 6; i++) begin
      rst_i = (i == 2 || i == 3); divided_clock_i = i[0]; step(1);
      chk(pb_drive_en_o[1], 1'b1);
      chk(pb_drive_val_o[1], i[0]);
    end
    rst_i = 0;
    $display("clock out test done");
    print_verdict();
  end
endmodule // pabo_top_test
